// ==== rtl/rcp_port.sv ====
// half-duplex ascii command port: receiver, parser, responder
`timescale 1ns/10ps
`default_nettype none
module rcp_port #(
    parameter int unsigned BIT_CYC_LO = rcp_pkg::CYC_LO
) (
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic [1:0]        baud_sel_in,
    input  wire logic [6:0]        unit_addr_in,
    input  wire logic              rx_in,
    output logic                   tx_out,
    output logic                   tx_oe_out,
    output logic                   cmd_valid_out,
    input  wire logic              cmd_ready_in,
    output rcp_pkg::rcp_cmd_s      cmd_out,
    input  wire logic              rsp_valid_in,
    output logic                   rsp_ready_out,
    input  wire rcp_pkg::rcp_rsp_s rsp_in
);
    import rcp_pkg::*;

    typedef enum logic [1:0] {M_RX, M_PUSH, M_WAIT, M_TX} rcp_mode_e;
    typedef enum logic [2:0] {P_IDLE, P_ADDR, P_CHAN, P_CODE0, P_CODE1, P_VALUE, P_SKIP} rcp_parse_e;
    typedef enum logic [2:0] {T_IDLE, T_HEAD, T_SIGN, T_DIGIT, T_CR, T_END} rcp_tx_e;

    rcp_mode_e      mode;
    rcp_parse_e     pstate;
    rcp_tx_e        tstate;
    logic [CYC_W-1:0] bit_cyc;
    logic [CYC_W-1:0] rx_cnt;
    logic [CYC_W-1:0] tx_cnt;
    logic           rx_busy;
    logic [3:0]     rx_bit;
    logic [6:0]     rx_data;
    logic           rx_perr;
    logic           rx_stb;
    logic           rx_err;
    logic           tx_busy;
    logic [3:0]     tx_bit;
    logic [9:0]     tx_shift;
    logic           tx_load;
    logic [6:0]     tx_char;
    rcp_cmd_s       cmd;
    logic [2:0]     ndig;
    logic [19:0]    next_value;
    logic           buf_ready;
    logic [2:0]     hidx;
    logic [2:0]     didx;
    logic [3:0]     dig;
    logic           started;
    logic           neg;
    logic [15:0]    mag;
    logic           emit;

    // ------------------------------------------------------------
    // bit timing
    // ------------------------------------------------------------
    always_comb begin
        case (baud_sel_in)
            SEL_MID: bit_cyc = CYC_W'(CYC_MID);
            SEL_LO:  bit_cyc = CYC_W'(BIT_CYC_LO);
            default: bit_cyc = CYC_W'(CYC_HI);
        endcase
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rx_busy <= 1'b0;
            rx_cnt  <= '0;
            rx_bit  <= 4'h0;
            rx_data <= 7'h00;
            rx_perr <= 1'b0;
            rx_stb  <= 1'b0;
            rx_err  <= 1'b0;
        end else begin
            rx_stb <= 1'b0;
            if (!rx_busy) begin
                if (mode == M_RX && !rx_in) begin
                    rx_busy <= 1'b1;
                    rx_cnt  <= bit_cyc >> 1;
                    rx_bit  <= 4'h0;
                    rx_perr <= 1'b0;
                end
            end else if (rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 1'b1;
            end else begin
                rx_cnt <= bit_cyc - 1'b1;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0) begin
                    rx_busy <= !rx_in;
                end else if (rx_bit < BIT_PAR) begin
                    rx_data <= {rx_in, rx_data[6:1]};
                end else if (rx_bit == BIT_PAR) begin
                    rx_perr <= (even_bit(rx_data) != rx_in);
                end else begin
                    rx_busy <= 1'b0;
                    rx_stb  <= 1'b1;
                    rx_err  <= rx_perr || !rx_in;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // message parser
    // ------------------------------------------------------------
    assign next_value = {cmd.value, 4'h0} - {2'h0, cmd.value, 2'h0} - {3'h0, cmd.value, 1'b0}
                      + {16'h0, rx_data[3:0] - 4'h0};

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pstate <= P_IDLE;
            cmd    <= '0;
            ndig   <= 3'h0;
        end else if (rx_stb) begin
            if (rx_err) begin
                pstate <= P_SKIP;
            end else if (rx_data == CH_HASH) begin
                pstate <= P_ADDR;
            end else begin
                case (pstate)
                    P_ADDR: begin
                        pstate <= (rx_data == unit_addr_in || rx_data == CH_WILD) ? P_CHAN : P_SKIP;
                    end
                    P_CHAN: begin
                        pstate <= is_digit(rx_data) ? P_CODE0 : P_SKIP;
                    end
                    P_CODE0: begin
                        cmd.code0 <= rx_data;
                        pstate    <= is_letter(rx_data) ? P_CODE1 : P_SKIP;
                    end
                    P_CODE1: begin
                        cmd.code1 <= rx_data;
                        cmd.value <= 16'h0000;
                        ndig      <= 3'h0;
                        pstate    <= is_letter(rx_data) ? P_VALUE : P_SKIP;
                    end
                    P_VALUE: begin
                        if (rx_data == CH_CR) begin
                            cmd.has_value <= (ndig != 3'h0);
                            pstate        <= P_IDLE;
                        end else if (rx_data == CH_SPACE && ndig == 3'h0) begin
                            pstate <= P_VALUE;
                        end else if (is_digit(rx_data) && ndig != MAX_DIGITS && next_value[19:16] == 4'h0) begin
                            cmd.value <= next_value[15:0];
                            ndig      <= ndig + 3'h1;
                        end else begin
                            pstate <= P_SKIP;
                        end
                    end
                    P_SKIP: pstate  <= P_SKIP;
                    default: pstate <= P_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // exchange sequencing and line driver
    // ------------------------------------------------------------
    assign rsp_ready_out = (mode == M_WAIT);

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            mode      <= M_RX;
            tx_oe_out <= 1'b0;
        end else begin
            case (mode)
                M_RX: begin
                    if (rx_stb && !rx_err && pstate == P_VALUE && rx_data == CH_CR) begin
                        mode <= M_PUSH;
                    end
                end
                M_PUSH: begin
                    if (buf_ready) begin
                        mode <= M_WAIT;
                    end
                end
                M_WAIT: begin
                    if (rsp_valid_in) begin
                        mode      <= M_TX;
                        tx_oe_out <= 1'b1;
                    end
                end
                M_TX: begin
                    if (tstate == T_END && !tx_busy) begin
                        mode      <= M_RX;
                        tx_oe_out <= 1'b0;
                    end
                end
                default: mode <= M_RX;
            endcase
        end
    end

    rcp_buf2 u_buf (
        .core_clk_in   (core_clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (mode == M_PUSH),
        .in_ready_out  (buf_ready),
        .in_data_in    (cmd),
        .out_valid_out (cmd_valid_out),
        .out_ready_in  (cmd_ready_in),
        .out_data_out  (cmd_out)
    );

    // ------------------------------------------------------------
    // response formatter
    // ------------------------------------------------------------
    always_comb begin
        tx_load = 1'b0;
        tx_char = CH_ZERO;
        emit    = (dig != 4'h0) || started || (didx == LAST_POW);
        case (tstate)
            T_HEAD: begin
                tx_load = !tx_busy;
                case (hidx)
                    3'h0:    tx_char = CH_HASH;
                    3'h1:    tx_char = unit_addr_in;
                    3'h2:    tx_char = CH_ZERO;
                    3'h3:    tx_char = cmd.code0;
                    default: tx_char = cmd.code1;
                endcase
            end
            T_SIGN: begin
                tx_load = !tx_busy;
                tx_char = CH_MINUS;
            end
            T_DIGIT: begin
                tx_load = !tx_busy && emit && (mag < pow10(didx));
                tx_char = CH_ZERO + {3'h0, dig};
            end
            T_CR: begin
                tx_load = !tx_busy;
                tx_char = CH_CR;
            end
            default: tx_load = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tstate  <= T_IDLE;
            hidx    <= 3'h0;
            didx    <= 3'h0;
            dig     <= 4'h0;
            started <= 1'b0;
            neg     <= 1'b0;
            mag     <= 16'h0000;
        end else begin
            case (tstate)
                T_IDLE: begin
                    if (mode == M_WAIT && rsp_valid_in) begin
                        tstate  <= T_HEAD;
                        hidx    <= 3'h0;
                        didx    <= 3'h0;
                        dig     <= 4'h0;
                        started <= 1'b0;
                        neg     <= rsp_in.value[15];
                        mag     <= rsp_in.value[15] ? 16'h0000 - rsp_in.value : rsp_in.value;
                    end
                end
                T_HEAD: begin
                    if (tx_load) begin
                        hidx <= hidx + 3'h1;
                        if (hidx == LAST_HEAD) begin
                            tstate <= neg ? T_SIGN : T_DIGIT;
                        end
                    end
                end
                T_SIGN: begin
                    if (tx_load) begin
                        tstate <= T_DIGIT;
                    end
                end
                T_DIGIT: begin
                    if (mag >= pow10(didx)) begin
                        mag <= mag - pow10(didx);
                        dig <= dig + 4'h1;
                    end else if (tx_load || !emit) begin
                        started <= started || tx_load;
                        dig     <= 4'h0;
                        didx    <= didx + 3'h1;
                        if (didx == LAST_POW) begin
                            tstate <= T_CR;
                        end
                    end
                end
                T_CR: begin
                    if (tx_load) begin
                        tstate <= T_END;
                    end
                end
                T_END: begin
                    if (!tx_busy) begin
                        tstate <= T_IDLE;
                    end
                end
                default: tstate <= T_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tx_busy  <= 1'b0;
            tx_bit   <= 4'h0;
            tx_cnt   <= '0;
            tx_shift <= 10'h3ff;
            tx_out   <= 1'b1;
        end else if (tx_load) begin
            tx_busy  <= 1'b1;
            tx_bit   <= 4'h0;
            tx_cnt   <= bit_cyc - 1'b1;
            tx_shift <= {1'b1, even_bit(tx_char), tx_char, 1'b0};
            tx_out   <= 1'b0;
        end else if (tx_busy) begin
            if (tx_cnt != '0) begin
                tx_cnt <= tx_cnt - 1'b1;
            end else if (tx_bit == BIT_STOP) begin
                tx_busy <= 1'b0;
                tx_out  <= 1'b1;
            end else begin
                tx_cnt   <= bit_cyc - 1'b1;
                tx_bit   <= tx_bit + 4'h1;
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_out   <= tx_shift[1];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_no_talk_listen: assert property (@(posedge core_clk_in) disable iff (srst_in)
        tx_oe_out |-> !rx_busy && !rx_stb) else $error("receiver active while driving");
    a_start_bit_low: assert property (@(posedge core_clk_in) disable iff (srst_in)
        tx_load |=> !tx_out [*3]) else $error("start bit not low");
    a_even_parity: assert property (@(posedge core_clk_in) disable iff (srst_in)
        tx_load |=> ^tx_shift[8:1] == 1'b0) else $error("odd parity on transmit");
    a_bit_period: assert property (@(posedge core_clk_in) disable iff (srst_in)
        tx_busy |-> tx_cnt < bit_cyc) else $error("bit counter out of range");
    a_digit_ascii: assert property (@(posedge core_clk_in) disable iff (srst_in)
        tx_load && tstate == T_DIGIT |-> is_digit(tx_char)) else $error("non decimal digit sent");
    a_error_discard: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rx_stb && rx_err |=> pstate == P_SKIP && mode == M_RX) else $error("bad character not discarded");
    a_reply_starts: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rsp_valid_in && rsp_ready_out |=> tx_oe_out && tstate == T_HEAD ##1 !tx_out) else $error("no reply started");
    a_head_hash: assert property (@(posedge core_clk_in) disable iff (srst_in)
        tx_load && tstate == T_HEAD && hidx == 3'h0 |-> tx_char == CH_HASH) else $error("reply not opened by hash");
    a_addr_filter: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rx_stb && !rx_err && pstate == P_ADDR && rx_data != CH_HASH && rx_data != unit_addr_in
        && rx_data != CH_WILD |=> pstate == P_SKIP) else $error("foreign address accepted");
    a_cr_ends_msg: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rx_stb && !rx_err && pstate == P_VALUE && rx_data == CH_CR |=> mode == M_PUSH) else $error("message not closed");
    a_line_release: assert property (@(posedge core_clk_in) disable iff (srst_in)
        tstate == T_END && !tx_busy |=> !tx_oe_out && tx_out) else $error("driver held after last stop bit");
endmodule // rcp_port
`default_nettype wire

// ==== rtl/rcp_pkg.sv ====
// constants, types and helpers of the serial command port
//
// Overview of operation
// - half-duplex pair; never transmit and receive at the same time.
// - each character is start, seven data, parity, stop: ten bit periods.
// - ascii payload with even parity, generated on transmit, checked on receive.
// - bit rate selectable as 19200, 9600 or 2400 baud, same at both ends.
// - numeric values travel as ascii decimal digits.
// - any error in a message discards it: no change, no response.
// - a valid read command returns the parameter's current value.
// - a valid write command updates the parameter, then echoes the new value.
// - responses use the same message layout as commands.
// - message is '#', address, channel digit, two-letter code, optional value, carriage return.
// - address is 0-9, a-z or A-Z; wildcard '?' always accepted.
// - command without value reads; command with value writes.
// - carriage return ends a message; spaces allowed between code and value.
package rcp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned BAUD_HI     = 19200;
    localparam int unsigned BAUD_MID    = 9600;
    localparam int unsigned BAUD_LO     = 2400;
    localparam int unsigned CYC_HI      = (CLK_HZ + BAUD_HI / 2) / BAUD_HI;
    localparam int unsigned CYC_MID     = (CLK_HZ + BAUD_MID / 2) / BAUD_MID;
    localparam int unsigned CYC_LO      = (CLK_HZ + BAUD_LO / 2) / BAUD_LO;
    localparam int unsigned CYC_W       = 14;
    localparam logic [1:0]  SEL_HI      = 2'h0;
    localparam logic [1:0]  SEL_MID     = 2'h1;
    localparam logic [1:0]  SEL_LO      = 2'h2;

    // ------------------------------------------------------------
    // framing and characters
    // ------------------------------------------------------------
    localparam logic [3:0]  BIT_PAR     = 4'h8;
    localparam logic [3:0]  BIT_STOP    = 4'h9;
    localparam logic [6:0]  CH_HASH     = 7'h23;
    localparam logic [6:0]  CH_CR       = 7'h0d;
    localparam logic [6:0]  CH_SPACE    = 7'h20;
    localparam logic [6:0]  CH_WILD     = 7'h3f;
    localparam logic [6:0]  CH_ZERO     = 7'h30;
    localparam logic [6:0]  CH_MINUS    = 7'h2d;
    localparam logic [2:0]  MAX_DIGITS  = 3'h5;
    localparam logic [2:0]  LAST_HEAD   = 3'h4;
    localparam logic [2:0]  LAST_POW    = 3'h4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0]  code0;
        logic [6:0]  code1;
        logic        has_value;
        logic [15:0] value;
    } rcp_cmd_s;

    typedef struct packed {
        logic [15:0] value;
    } rcp_rsp_s;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_digit(input logic [6:0] c);
        return (c >= 7'h30) && (c <= 7'h39);
    endfunction

    function automatic logic is_letter(input logic [6:0] c);
        return ((c >= 7'h41) && (c <= 7'h5a)) || ((c >= 7'h61) && (c <= 7'h7a));
    endfunction

    function automatic logic even_bit(input logic [6:0] c);
        return ^c;
    endfunction

    function automatic logic [15:0] pow10(input logic [2:0] i);
        case (i)
            3'h0:    return 16'h2710;
            3'h1:    return 16'h03e8;
            3'h2:    return 16'h0064;
            3'h3:    return 16'h000a;
            default: return 16'h0001;
        endcase
    endfunction
endpackage

// ==== rtl/rcp_buf2.sv ====
// two-entry command buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module rcp_buf2 (
    input  wire logic            core_clk_in,
    input  wire logic            srst_in,
    input  wire logic            in_valid_in,
    output logic                 in_ready_out,
    input  wire rcp_pkg::rcp_cmd_s in_data_in,
    output logic                 out_valid_out,
    input  wire logic            out_ready_in,
    output rcp_pkg::rcp_cmd_s    out_data_out
);
    import rcp_pkg::*;

    rcp_cmd_s   mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    assign in_ready_out  = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out  = mem[rd_ptr];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // rcp_buf2
`default_nettype wire

// ==== tb/rcp_host.sv ====
// host-side serial partner that sends commands and collects replies
`timescale 1ns/10ps
`default_nettype none
module rcp_host #(
    parameter int BIT_CYC = 20
) (
    input  wire logic core_clk_in,
    input  wire logic line_in,
    input  wire logic tx_oe_in,
    output var logic  host_tx_out
);
    string      reply;
    string      last;
    int         bad_frames;
    int         overlap;
    logic       busy;
    logic [9:0] fr;
    event       got;
    initial begin
        host_tx_out = 1'b1;
        busy        = 1'b0;
        reply       = "";
        bad_frames  = 0;
        overlap     = 0;
    end
    // ------------------------------------------------------------
    // command sending, one frame per character
    // ------------------------------------------------------------
    task automatic send_msg(input string m, input int bad_at);
        logic [9:0] f;
        byte        b;
        busy = 1'b1;
        for (int k = 0; k < m.len(); k++) begin
            b = m[k];
            f = {1'b1, (^b[6:0]) ^ (k == bad_at), b[6:0], 1'b0};
            for (int i = 0; i < 10; i++) begin
                @(negedge core_clk_in);
                host_tx_out = f[i];
                repeat (BIT_CYC - 1) @(negedge core_clk_in);
            end
        end
        busy = 1'b0;
    endtask
    always @(posedge core_clk_in) if (busy && tx_oe_in) overlap++;
    // ------------------------------------------------------------
    // reply collection
    // ------------------------------------------------------------
    always begin
        @(negedge line_in iff tx_oe_in);
        repeat (BIT_CYC / 2) @(posedge core_clk_in);
        for (int i = 0; i < 10; i++) begin
            fr[i] = line_in;
            if (i < 9) repeat (BIT_CYC) @(posedge core_clk_in);
        end
        if (fr[0] || !fr[9] || ^fr[8:1]) bad_frames++;
        reply = $sformatf("%s%c", reply, fr[7:1]);
        if (fr[7:1] == 7'h0d) begin
            last  = reply;
            reply = "";
            -> got;
        end
    end
endmodule // rcp_host
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the serial command port
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rcp_pkg::*;
    localparam int B = 20;
    logic        core_clk_in;
    logic        srst_in;
    logic [1:0]  baud_sel;
    logic        host_tx;
    logic        tx;
    logic        oe;
    logic        line;
    logic        cmd_valid;
    logic        cmd_ready;
    rcp_cmd_s    cmd;
    logic        rsp_valid;
    logic        rsp_ready;
    rcp_rsp_s    rsp;
    logic [30:0] exp_cmd[$];
    string       exp_msg[$];
    int          errors;
    int          checks_done;
    int          tno;
    logic [15:0] v;
    logic [15:0] r;
    assign line = oe ? tx : host_tx;
    rcp_port #(.BIT_CYC_LO(B)) rcp_port_inst (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .baud_sel_in(baud_sel), .unit_addr_in(7'h30),
        .rx_in(line), .tx_out(tx), .tx_oe_out(oe), .cmd_valid_out(cmd_valid), .cmd_ready_in(cmd_ready),
        .cmd_out(cmd), .rsp_valid_in(rsp_valid), .rsp_ready_out(rsp_ready), .rsp_in(rsp));
    rcp_host #(.BIT_CYC(B)) rcp_host_inst (.core_clk_in(core_clk_in), .line_in(line), .tx_oe_in(oe),
        .host_tx_out(host_tx));
    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_val(input logic [31:0] e, input logic [31:0] a);
        checks_done++;
        if (a !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic chk_msg(input string e, input string a);
        checks_done++;
        if (a != e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchers and core side
    // ------------------------------------------------------------
    always @(posedge core_clk_in) if (!srst_in && cmd_valid && cmd_ready) begin
        if (exp_cmd.size() == 0) chk_val(32'h0, {1'b1, cmd});
        else chk_val({1'b0, exp_cmd.pop_front()}, {1'b0, cmd});
    end
    always @(rcp_host_inst.got) begin
        if (exp_msg.size() == 0) chk_msg("", rcp_host_inst.last);
        else chk_msg(exp_msg.pop_front(), rcp_host_inst.last);
    end
    always @(negedge core_clk_in) cmd_ready <= 1'($urandom_range(0, 1));
    task automatic run(input string m, input int bad, input logic [30:0] ec, input logic [15:0] rv,
                       input string em);
        int w;
        if (em != "") begin
            exp_cmd.push_back(ec);
            exp_msg.push_back(em);
        end
        rcp_host_inst.send_msg(m, bad);
        w = 0;
        while (em != "" && !rsp_ready && w < 40 * B) begin
            @(negedge core_clk_in);
            w++;
        end
        if (em != "") begin
            rsp_valid = 1'b1;
            rsp       = rv;
            @(negedge core_clk_in);
            rsp_valid = 1'b0;
            rsp       = ~rv;
        end
        else repeat (20 * B) @(negedge core_clk_in);
        w = 0;
        while ((exp_msg.size() + exp_cmd.size()) != 0 && w < 300 * B) begin
            @(negedge core_clk_in);
            w++;
        end
        chk_val(32'h0, 32'(exp_msg.size() + exp_cmd.size()));
        repeat (B) @(negedge core_clk_in);
        chk_val(32'h0, {31'h0, oe});
        tno++;
        $display("test %0d done", tno);
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    initial begin
        #3ms;
        errors++;
        tally_and_finish();
    end
    initial begin
        srst_in     = 1'b1;
        baud_sel    = SEL_LO;
        rsp_valid   = 1'b0;
        rsp         = '0;
        errors      = 0;
        checks_done = 0;
        tno         = 0;
        void'($urandom(32'h16e8));
        repeat (6) @(negedge core_clk_in);
        srst_in = 1'b0;
        run("#00TT\015", -1, {7'h54, 7'h54, 1'b0, 16'h0}, 16'd1007, "#00TT1007\015");
        run("#?5EM   820\015", -1, {7'h45, 7'h4d, 1'b1, 16'd820}, 16'd820, "#00EM820\015");
        run("#00AZ65535\015", -1, {7'h41, 7'h5a, 1'b1, 16'hffff}, 16'h8200, "#00AZ-32256\015");
        run("#00TT\015", 3, 31'h0, 16'h0, "");
        run("#50TT\015", -1, 31'h0, 16'h0, "");
        run("#00T1\015", -1, 31'h0, 16'h0, "");
        run("#00RT70000\015", -1, 31'h0, 16'h0, "");
        run("#00RT1 2\015", -1, 31'h0, 16'h0, "");
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom_range(0, 65535));
            r = 16'($urandom);
            run($sformatf("#00DR%0d\015", v), -1, {7'h44, 7'h52, 1'b1, v}, r,
                $sformatf("#00DR%0d\015", $signed(r)));
        end
        chk_val(32'h0, 32'(rcp_host_inst.bad_frames));
        chk_val(32'h0, 32'(rcp_host_inst.overlap));
        baud_sel = SEL_HI;
        @(negedge core_clk_in) chk_val(32'(CYC_HI), 32'(rcp_port_inst.bit_cyc));
        baud_sel = SEL_MID;
        @(negedge core_clk_in) chk_val(32'(CYC_MID), 32'(rcp_port_inst.bit_cyc));
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
